// >>> common/plcm_pkg.sv
// Package: offsets, field layout, reset values and timing counts
package plcm_pkg;
	// Configuration byte offsets
	localparam logic [7:0] OFF_HOLD_LIMIT = 8'h0d;
	localparam logic [7:0] OFF_MEM_BASE   = 8'h14;
	localparam logic [7:0] OFF_MIN_GRANT  = 8'h3e;
	localparam logic [7:0] OFF_MAX_LAT    = 8'h3f;

	// Reset values
	localparam logic [7:0]  RST_HOLD_LIMIT = 8'h00;
	localparam logic [31:0] RST_MEM_BASE   = 32'h00000000;
	localparam logic [7:0]  RST_MIN_GRANT  = 8'h50;
	localparam logic [7:0]  RST_MAX_LAT    = 8'h0a;

	// Hold limit field: bits 7..3, each unit is eight bus clocks
	localparam int          HOLD_FIELD_LSB = 3;
	localparam int          HOLD_FIELD_W   = 5;
	localparam int          HOLD_UNIT_CLKS = 8;
	localparam int          HOLD_UNIT_SH   = 3;

	// Latency hints are in 250 ns units; clock period 20 ns
	localparam int          HINT_UNIT_NS   = 250;
	localparam int          CLK_PERIOD_NS  = 20;

	// Memory base register fields
	localparam int          MB_VALID_BIT   = 0;
	localparam int          MB_BELOW1M_BIT = 1;
	localparam int          MB_ADDR_LSB    = 8;

	// Loaded bit ranges inside the hint bytes
	localparam int          MAX_ACCESS_INTERVAL_LD_LSB  = 1;
	localparam int          MAX_ACCESS_INTERVAL_LD_W    = 5;
	localparam int          MIN_BURST_GRANT_LD_LSB  = 4;
	localparam int          MIN_BURST_GRANT_LD_W    = 4;

	// Layout of the EEPROM setup word
	localparam int          SW_MAX_ACCESS_INTERVAL_LSB  = 0;
	localparam int          SW_MIN_BURST_GRANT_LSB  = 5;
	localparam int          SW_BELOW1M_BIT = 9;
	localparam int          SW_MEMDIS_BIT  = 10;
endpackage

// >>> logic/plcm_hold_timer.sv
// Bus-hold limit counter for master transactions
`timescale 1ns/1ps
module plcm_hold_timer (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic [4:0] hold_limit,
	input  wire logic       frame_start,
	input  wire logic       master_active,
	input  wire logic       gnt_n,
	output logic            bus_release
);
	logic [7:0] count;

	////////////////////////////////////////////////////////////////////////
	// Count down from limit times eight; reload on every frame start
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count <= 8'h00;
		end else if (frame_start) begin
			count <= {hold_limit, 3'h0};
		end else if (master_active && count != 8'h00) begin
			count <= count - 8'h01;
		end
	end

	// Zero count is expiry; give the bus up only once grant is gone
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			bus_release <= 1'h0;
		end else begin
			bus_release <= master_active && !frame_start &&
				count == 8'h00 && gnt_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	restart_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		frame_start |=> count == {$past(hold_limit), 3'h0})
		else $error("hold counter not restarted at frame start");

	count_down_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		master_active && !frame_start && count != 8'h00
		|=> count == $past(count) - 8'h01)
		else $error("hold counter failed to count down");

	release_cause_a: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		bus_release |-> $past(count) == 8'h00 && $past(gnt_n))
		else $error("bus released before expiry and grant loss");

	release_due_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		master_active && !frame_start && count == 8'h00 && gnt_n
		|=> bus_release)
		else $error("bus not released after expiry");
endmodule

// >>> logic/plcm_config_regs.sv
// Configuration registers: bus-hold limit, latency hints, memory base
`timescale 1ns/1ps
module plcm_config_regs (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_ack,
	input  wire logic        eeprom_load,
	input  wire logic [15:0] eeprom_setup_word,
	input  wire logic [15:0] eeprom_base_hi,
	input  wire logic [15:0] eeprom_base_lo,
	input  wire logic [7:0]  forced_setup_mode,
	input  wire logic        frame_start,
	input  wire logic        master_active,
	input  wire logic        gnt_n,
	output logic             bus_release,
	output logic [31:0]      memory_window_base,
	output logic             memory_window_valid
);
	logic [4:0]  bus_hold_limit;
	logic [7:0]  min_burst_grant;
	logic [7:0]  max_access_interval;
	logic [23:0] mem_addr;
	logic        mem_valid;
	logic        below_one_megabyte_flag;
	logic        mem_disabled;
	logic [31:0] next_rdata;

	// Dword hit test on a byte offset
	function automatic logic dw_hit(input logic [7:0] a, input logic [7:0] o);
		dw_hit = a[7:2] == o[7:2];
	endfunction

	// Byte enable lane of a byte offset
	function automatic logic lane(input logic [3:0] be, input logic [7:0] o);
		lane = be[o[1:0]];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus-hold limit: only bits 7..3 are kept, low bits stay zero
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			bus_hold_limit <= plcm_pkg::RST_HOLD_LIMIT[7:3];
		end else if (cfg_wr && dw_hit(cfg_addr, plcm_pkg::OFF_HOLD_LIMIT) &&
				lane(cfg_be, plcm_pkg::OFF_HOLD_LIMIT)) begin
			bus_hold_limit <= cfg_wdata[15:11];
		end
	end

	// Latency hints: read-only, partly refilled by auto-initialisation
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			min_burst_grant     <= plcm_pkg::RST_MIN_GRANT;
			max_access_interval <= plcm_pkg::RST_MAX_LAT;
		end else if (eeprom_load) begin
			max_access_interval[5:1] <= eeprom_setup_word[4:0];
			min_burst_grant[7:4]     <= eeprom_setup_word[8:5];
		end
	end

	// Setup word flags: below-1MB placement and memory disable
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			below_one_megabyte_flag <= 1'h0;
			mem_disabled            <= 1'h0;
		end else if (eeprom_load) begin
			below_one_megabyte_flag <=
				eeprom_setup_word[plcm_pkg::SW_BELOW1M_BIT];
			mem_disabled <= eeprom_setup_word[plcm_pkg::SW_MEMDIS_BIT];
		end
	end

	// Memory base: forced load wins over a host write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mem_addr  <= plcm_pkg::RST_MEM_BASE[31:8];
			mem_valid <= 1'h0;
		end else if (eeprom_load && forced_setup_mode[0]) begin
			mem_addr  <= {eeprom_base_hi, eeprom_base_lo[15:8]};
			mem_valid <= eeprom_base_lo[0];
		end else if (cfg_wr && !mem_disabled &&
				dw_hit(cfg_addr, plcm_pkg::OFF_MEM_BASE)) begin
			if (cfg_be[0]) begin
				mem_valid <= cfg_wdata[0];
			end
			if (cfg_be[1]) begin
				mem_addr[7:0] <= cfg_wdata[15:8];
			end
			if (cfg_be[2]) begin
				mem_addr[15:8] <= cfg_wdata[23:16];
			end
			if (cfg_be[3]) begin
				mem_addr[23:16] <= cfg_wdata[31:24];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; reserved and unmapped bits return zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (dw_hit(cfg_addr, plcm_pkg::OFF_HOLD_LIMIT)) begin
			next_rdata[15:8] = {bus_hold_limit, 3'h0};
		end else if (dw_hit(cfg_addr, plcm_pkg::OFF_MEM_BASE)) begin
			// A disabled window reads as an absent register
			if (!mem_disabled) begin
				next_rdata = {mem_addr, 5'h00, 1'h0,
					below_one_megabyte_flag, mem_valid};
			end
		end else if (dw_hit(cfg_addr, plcm_pkg::OFF_MIN_GRANT)) begin
			next_rdata[31:16] = {max_access_interval, min_burst_grant};
		end
	end

	// Registered answer one cycle after any access
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack   <= 1'h0;
		end else begin
			cfg_rdata <= cfg_rd ? next_rdata : 32'h00000000;
			cfg_ack   <= cfg_rd || cfg_wr;
		end
	end

	// Decoder-facing copy of the memory window
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			memory_window_base  <= 32'h00000000;
			memory_window_valid <= 1'h0;
		end else begin
			memory_window_base  <= {mem_addr, 8'h00};
			memory_window_valid <= mem_valid && !mem_disabled;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter lives in its own module so it can be reused per master
	plcm_hold_timer u_hold_timer (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.hold_limit   (bus_hold_limit),
		.frame_start  (frame_start),
		.master_active(master_active),
		.gnt_n        (gnt_n),
		.bus_release  (bus_release)
	);

	////////////////////////////////////////////////////////////////////////
	hold_reserved_a: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		cfg_ack && $past(cfg_rd) &&
		$past(cfg_addr[7:2]) == plcm_pkg::OFF_HOLD_LIMIT[7:2]
		|-> cfg_rdata[10:8] == 3'h0)
		else $error("hold reserved bits not zero");

	hold_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		cfg_wr && cfg_be[1] &&
		cfg_addr[7:2] == plcm_pkg::OFF_HOLD_LIMIT[7:2]
		|=> bus_hold_limit == $past(cfg_wdata[15:11]))
		else $error("hold limit write lost");

	hint_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		eeprom_load |=> max_access_interval[5:1] ==
		$past(eeprom_setup_word[4:0]) &&
		max_access_interval[7:6] == plcm_pkg::RST_MAX_LAT[7:6] &&
		max_access_interval[0] == plcm_pkg::RST_MAX_LAT[0])
		else $error("max latency load wrong");

	grant_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		eeprom_load |=> min_burst_grant == {$past(eeprom_setup_word[8:5]),
		plcm_pkg::RST_MIN_GRANT[3:0]})
		else $error("min grant load wrong");

	forced_base_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		eeprom_load && forced_setup_mode[0]
		|=> mem_addr == {$past(eeprom_base_hi), $past(eeprom_base_lo[15:8])}
		##1 memory_window_base[31:8] == $past(mem_addr))
		else $error("forced base load wrong");

	mem_type_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		cfg_ack && $past(cfg_rd) &&
		$past(cfg_addr[7:2]) == plcm_pkg::OFF_MEM_BASE[7:2]
		|-> cfg_rdata[2] == 1'h0 &&
		cfg_rdata[7:3] == 5'h00)
		else $error("memory placement bit 2 set");

	mem_disable_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		eeprom_load && eeprom_setup_word[plcm_pkg::SW_MEMDIS_BIT]
		##1 !eeprom_load |=> !memory_window_valid)
		else $error("disabled window still valid");

	reset_vals_a: assert property (@(posedge ref_clk)
		!resetn |=> min_burst_grant == plcm_pkg::RST_MIN_GRANT &&
		max_access_interval == plcm_pkg::RST_MAX_LAT &&
		bus_hold_limit == 5'h00 && mem_addr == 24'h000000 &&
		!mem_valid)
		else $error("reset values wrong");
endmodule

// >>> verification/plcm_bus_partner.sv
// Arbiter and master sequencer model facing the hold timer
`timescale 1ns/1ps
module plcm_bus_partner (
	input  wire logic       ref_clk,
	input  wire logic       go,
	input  wire logic [7:0] grant_cycles,
	input  wire logic       bus_release,
	output logic            frame_start,
	output logic            master_active,
	output logic            gnt_n
);
	logic [7:0] left;
	initial begin
		frame_start = 1'h0;
		master_active = 1'h0;
		gnt_n = 1'h1;
		left = 8'h00;
	end
	// Grant held for grant_cycles plus one cycles, then withdrawn; master quits on release
	always @(posedge ref_clk) begin
		frame_start <= go;
		if (go) begin
			master_active <= 1'h1;
			gnt_n <= 1'h0;
			left <= grant_cycles;
		end else begin
			if (left != 8'h00)
				left <= left - 8'h01;
			else
				gnt_n <= 1'h1;
			if (bus_release)
				master_active <= 1'h0;
		end
	end
endmodule

// >>> verification/plcm_config_regs_tb.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module plcm_config_regs_tb;
	typedef struct {
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] data;
	} plcm_row_s;
	logic        ref_clk, resetn, cfg_rd, cfg_wr, cfg_ack, eeprom_load;
	logic        go, frame_start, master_active, gnt_n, bus_release;
	logic        memory_window_valid;
	logic [7:0]  cfg_addr, forced_setup_mode, grant_cycles;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, memory_window_base, rd;
	logic [15:0] eeprom_setup_word, eeprom_base_hi, eeprom_base_lo;
	int          n_fail, n_tests, n;
	plcm_row_s   rows [14];
	logic [7:0]  lims [3] = '{8'h00, 8'h08, 8'h18};

	plcm_config_regs dut (.ref_clk, .resetn, .cfg_rd, .cfg_wr, .cfg_addr,
		.cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .eeprom_load,
		.eeprom_setup_word, .eeprom_base_hi, .eeprom_base_lo,
		.forced_setup_mode, .frame_start, .master_active, .gnt_n,
		.bus_release, .memory_window_base, .memory_window_valid);
	plcm_bus_partner partner (.ref_clk, .go, .grant_cycles, .bus_release,
		.frame_start, .master_active, .gnt_n);

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One config access; waits an edge first so strobes never re-rise at once
	task automatic cfg(input plcm_row_s r);
		@(posedge ref_clk);
		#1;
		cfg_wr = r.wr;
		cfg_rd = !r.wr;
		cfg_addr = r.addr;
		cfg_be = r.be;
		cfg_wdata = r.wr ? r.data : 32'h0;
		@(posedge ref_clk);
		#1;
		cfg_wr = 1'h0;
		cfg_rd = 1'h0;
		check({31'h0, cfg_ack}, 32'h1);
		rd = cfg_rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		cfg('{1'h0, a, 4'h0, 32'h0});
		check(rd, exp);
	endtask
	task automatic load(input logic [15:0] w);
		@(posedge ref_clk);
		#1;
		eeprom_setup_word = w;
		eeprom_load = 1'h1;
		@(posedge ref_clk);
		#1;
		eeprom_load = 1'h0;
	endtask
	// Start a master frame, optionally restart it after gap cycles
	task automatic frame(input logic [7:0] lim, input int gap,
			input logic [7:0] gc, input int exp);
		cfg('{1'h1, 8'h0c, 4'h2, {16'h0, lim, 8'h00}});
		grant_cycles = gc;
		@(posedge ref_clk);
		#1;
		go = 1'h1;
		@(posedge ref_clk);
		#1;
		go = 1'h0;
		n = 0;
		while (bus_release !== 1'h1 && n < 200) begin
			@(posedge ref_clk);
			#1;
			n++;
			go = (n == gap);
		end
		check(32'(n), 32'(exp));
		if (n >= 200)
			complete_run();
		repeat (4) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		resetn = 1'h0;
		{cfg_rd, cfg_wr, eeprom_load, go} = 4'h0;
		{cfg_addr, cfg_be, cfg_wdata, grant_cycles} = 52'h0;
		eeprom_setup_word = 16'h0000;
		eeprom_base_hi = 16'h1234;
		eeprom_base_lo = 16'h5601;
		forced_setup_mode = 8'h00;
		n_fail = 0;
		n_tests = 0;
		// Reads carry the expected value in data
		rows = '{'{1'h0, 8'h0c, 4'h0, 32'h0}, '{1'h0, 8'h14, 4'h0, 32'h0},
			'{1'h0, 8'h3c, 4'h0, 32'h0a500000},
			'{1'h1, 8'h0c, 4'h2, 32'hfffff8ff},
			'{1'h0, 8'h0c, 4'h0, 32'h0000f800},
			'{1'h1, 8'h0c, 4'hd, 32'hffff00ff},
			'{1'h0, 8'h0c, 4'h0, 32'h0000f800},
			'{1'h1, 8'h14, 4'hf, 32'hffffffff},
			'{1'h0, 8'h14, 4'h0, 32'hffffff01},
			'{1'h1, 8'h14, 4'h2, 32'h00001200},
			'{1'h0, 8'h14, 4'h0, 32'hffff1201},
			'{1'h1, 8'h3c, 4'hf, 32'hffffffff},
			'{1'h0, 8'h3c, 4'h0, 32'h0a500000},
			'{1'h0, 8'h20, 4'h0, 32'h0}};
		repeat (3) @(posedge ref_clk);
		#1 resetn = 1'h1;
		foreach (rows[i]) begin
			cfg(rows[i]);
			if (!rows[i].wr) check(rd, rows[i].data);
		end
		// Setup word: hints, below-1MB flag, then forced base, then disable
		load(16'h0395);
		rdchk(8'h3c, 32'h2ac00000);
		rdchk(8'h14, 32'hffff1203);
		check(memory_window_base, 32'hffff1200);
		check({31'h0, memory_window_valid}, 32'h1);
		forced_setup_mode = 8'h01;
		load(16'h0395);
		rdchk(8'h14, 32'h12345603);
		check(memory_window_base, 32'h12345600);
		load(16'h0795);
		rdchk(8'h14, 32'h0);
		check({31'h0, memory_window_valid}, 32'h0);
		// Write while disabled must be lost once the window comes back
		cfg('{1'h1, 8'h14, 4'hf, 32'habcdef00});
		forced_setup_mode = 8'h00;
		load(16'h0395);
		rdchk(8'h14, 32'h12345603);
		check({31'h0, memory_window_valid}, 32'h1);
		// Hold limit expiry, grant kept long, restart mid-count
		foreach (lims[i]) frame(lims[i], 0, 8'h00, lims[i][7:3] * 8 + 2);
		frame(8'h08, 0, 8'h28, 42);
		frame(8'h08, 4, 8'h00, 15);
		// Reset in mid-run
		@(posedge ref_clk);
		#1 resetn = 1'h0;
		repeat (3) @(posedge ref_clk);
		#1 resetn = 1'h1;
		rdchk(8'h0c, 32'h0);
		rdchk(8'h3c, 32'h0a500000);
		rdchk(8'h14, 32'h0);
		check({31'h0, memory_window_valid}, 32'h0);
		check(memory_window_base, 32'h0);
		complete_run();
	end
endmodule
